// >>> include/nvs_pkg.sv
// nvs_pkg: constants for the two-wire settings register slave
// assumes: used by rtl/nvs_slave.sv and by the bench and monitor, referenced with nvs_pkg:: prefix
`default_nettype none
package nvs_pkg;
   // =======================================
   // identification and register bank
   localparam logic [3:0] DEV_CODE = 4'hA; // arbitrary device code
   localparam int NUM_REGS = 5;
   localparam logic [7:0] LAST_REG = 8'h04;
   localparam logic [7:0] REG_RST = 8'h00;
   localparam logic [7:0] PTR_RST = 8'h00;
   // =======================================
   // timing
   localparam int CLK_PERIOD_NS = 5;
   localparam int NV_WRITE_NS = 5000000; // nonvolatile write time
   localparam int NV_WRITE_CYC = NV_WRITE_NS / CLK_PERIOD_NS;
   localparam int PWRUP_NS = 1000; // power-up recall time
   localparam int PWRUP_CYC = (PWRUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // =======================================
   // link state machine
   typedef enum logic [2:0]
   {
      ST_IDLE = 3'b000,
      ST_ID = 3'b001,
      ST_ADDR = 3'b010,
      ST_DATA = 3'b011,
      ST_READ = 3'b100,
      ST_DONE = 3'b101
   } nvs_state_t;
endpackage
`default_nettype wire

// >>> rtl/nvs_slave.sv
// nvs_slave: two-wire slave giving access to five nonvolatile settings bytes
// assumes: scl/sda arrive from pins; clk_link is a free running sampling clock
`default_nettype none
module nvs_slave #(
   parameter int NV_WRITE_CYC = nvs_pkg::NV_WRITE_CYC
)(
   // system
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   // link sampling clock
   input wire logic clk_link,
   // serial pins
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   // address select straps
   input wire logic addr_select_pin_high,
   input wire logic addr_select_pin_mid,
   input wire logic addr_select_pin_low,
   // settings outputs
   output logic [7:0] reg0_out,
   output logic [7:0] reg1_out,
   output logic [7:0] reg2_out,
   output logic [7:0] reg3_out,
   output logic [7:0] reg4_out,
   output logic busy_out
);
   // =======================================
   // link domain: pin synchronisers
   logic [1:0] scl_sy_ff, sda_sy_ff, a_hi_ff, a_mid_ff, a_lo_ff;
   logic scl_d_ff, sda_d_ff;
   logic [1:0] busy_sy_ff;
   logic busy_core_ff, req_seen_ff;

   // two flops per pin before any use
   always_ff @(posedge clk_link or negedge nrst)
   begin
      if (!nrst)
      begin
         scl_sy_ff <= 2'h3;
         sda_sy_ff <= 2'h3;
         a_hi_ff <= 2'h0;
         a_mid_ff <= 2'h0;
         a_lo_ff <= 2'h0;
         busy_sy_ff <= 2'h3;
      end
      else if (ce)
      begin
         scl_sy_ff <= {scl_sy_ff[0], scl_in}; // clock is only ever an input
         sda_sy_ff <= {sda_sy_ff[0], sda_in};
         a_hi_ff <= {a_hi_ff[0], addr_select_pin_high};
         a_mid_ff <= {a_mid_ff[0], addr_select_pin_mid};
         a_lo_ff <= {a_lo_ff[0], addr_select_pin_low};
         busy_sy_ff <= {busy_sy_ff[0], busy_core_ff};
      end
   end

   // previous synchronised levels for edge detection
   always_ff @(posedge clk_link or negedge nrst)
   begin
      if (!nrst)
      begin
         scl_d_ff <= 1'b1;
         sda_d_ff <= 1'b1;
      end
      else if (ce)
      begin
         scl_d_ff <= scl_sy_ff[1];
         sda_d_ff <= sda_sy_ff[1];
      end
   end

   logic scl_s, sda_s, scl_rise, scl_fall, start_det, stop_det, busy_l;
   assign scl_s = scl_sy_ff[1];
   assign sda_s = sda_sy_ff[1];
   assign busy_l = busy_sy_ff[1];
   assign scl_rise = scl_s && !scl_d_ff;
   assign scl_fall = !scl_s && scl_d_ff;
   assign start_det = scl_s && scl_d_ff && sda_d_ff && !sda_s;
   assign stop_det = scl_s && scl_d_ff && !sda_d_ff && sda_s;

   // =======================================
   // link domain: protocol engine
   nvs_pkg::nvs_state_t st_ff;
   logic [3:0] bit_ff;
   logic [7:0] sh_ff, ptr_ff, wdata_ff, waddr_ff, tx_ff;
   logic ack_ph_ff, ack_ok_ff, rnw_ff, wr_ok_ff, req_tgl_ff;
   logic [7:0] rd_byte;
   logic [7:0] bank_ff [nvs_pkg::NUM_REGS];

   // read mux; bank only changes while busy holds the link idle
   assign rd_byte = (ptr_ff <= nvs_pkg::LAST_REG) ? bank_ff[ptr_ff[2:0]] : 8'h00;

   logic id_match;
   assign id_match = (sh_ff[7:4] == nvs_pkg::DEV_CODE)
      && (sh_ff[3:1] == {a_hi_ff[1], a_mid_ff[1], a_lo_ff[1]});

   // byte framing, acknowledge and pointer handling
   always_ff @(posedge clk_link or negedge nrst)
   begin
      if (!nrst)
      begin
         st_ff <= nvs_pkg::ST_IDLE;
         bit_ff <= 4'h0;
         sh_ff <= 8'h00;
         ptr_ff <= nvs_pkg::PTR_RST;
         wdata_ff <= 8'h00;
         waddr_ff <= 8'h00;
         tx_ff <= 8'h00;
         ack_ph_ff <= 1'b0;
         ack_ok_ff <= 1'b0;
         rnw_ff <= 1'b0;
         wr_ok_ff <= 1'b0;
         req_tgl_ff <= 1'b0;
         sda_out <= 1'b0;
         sda_oe <= 1'b0;
      end
      else if (ce)
      begin
         if (busy_l)
         begin
            // bus ignored during power-up and nv write
            st_ff <= nvs_pkg::ST_IDLE;
            sda_oe <= 1'b0;
            wr_ok_ff <= 1'b0;
         end
         else if (start_det)
         begin
            // start or repeated start
            st_ff <= nvs_pkg::ST_ID;
            bit_ff <= 4'h0;
            ack_ph_ff <= 1'b0;
            sda_oe <= 1'b0;
            wr_ok_ff <= 1'b0;
         end
         else if (stop_det)
         begin
            // complete write triggers store, else plain standby
            if (wr_ok_ff && st_ff == nvs_pkg::ST_DONE)
               req_tgl_ff <= ~req_tgl_ff;
            // mid-byte or early stop drops the write
            st_ff <= nvs_pkg::ST_IDLE;
            sda_oe <= 1'b0;
            wr_ok_ff <= 1'b0;
         end
         else if (st_ff != nvs_pkg::ST_IDLE && st_ff != nvs_pkg::ST_DONE)
         begin
            if (scl_rise && !ack_ph_ff)
            begin
               // sample on rising edge, msb first
               sh_ff <= {sh_ff[6:0], sda_s};
               bit_ff <= bit_ff + 4'h1;
            end
            else if (scl_rise && ack_ph_ff && st_ff == nvs_pkg::ST_READ)
               ack_ok_ff <= !sda_s;
            else if (scl_fall && !ack_ph_ff && bit_ff == 4'h8)
            begin
               // end of eighth bit: enter ack slot
               ack_ph_ff <= 1'b1;
               bit_ff <= 4'h0;
               unique case (st_ff)
                  nvs_pkg::ST_ID:
                  begin
                     if (id_match)
                     begin
                        sda_out <= 1'b0;
                        sda_oe <= 1'b1;
                        rnw_ff <= sh_ff[0];
                     end
                     else
                        st_ff <= nvs_pkg::ST_IDLE;
                  end
                  nvs_pkg::ST_ADDR:
                  begin
                     ptr_ff <= sh_ff;
                     waddr_ff <= sh_ff;
                     sda_out <= 1'b0;
                     sda_oe <= 1'b1;
                  end
                  nvs_pkg::ST_DATA:
                  begin
                     wdata_ff <= sh_ff;
                     sda_out <= 1'b0;
                     sda_oe <= 1'b1;
                  end
                  nvs_pkg::ST_READ:
                  begin
                     sda_oe <= 1'b0; // release for master ack
                     ptr_ff <= ptr_ff + 8'h01;
                  end
                  default: st_ff <= nvs_pkg::ST_IDLE;
               endcase
            end
            else if (scl_fall && ack_ph_ff)
            begin
               // end of ack slot: choose next phase
               ack_ph_ff <= 1'b0;
               sda_oe <= 1'b0;
               unique case (st_ff)
                  nvs_pkg::ST_ID:
                  begin
                     if (rnw_ff)
                     begin
                        st_ff <= nvs_pkg::ST_READ;
                        tx_ff <= {rd_byte[6:0], 1'b0};
                        sda_out <= rd_byte[7];
                        sda_oe <= !rd_byte[7];
                        bit_ff <= 4'h0;
                     end
                     else
                        st_ff <= nvs_pkg::ST_ADDR;
                  end
                  nvs_pkg::ST_ADDR: st_ff <= nvs_pkg::ST_DATA;
                  nvs_pkg::ST_DATA:
                  begin
                     wr_ok_ff <= 1'b1; // byte plus ack done
                     st_ff <= nvs_pkg::ST_DONE;
                  end
                  nvs_pkg::ST_READ:
                  begin
                     if (ack_ok_ff)
                     begin
                        tx_ff <= {rd_byte[6:0], 1'b0};
                        sda_out <= rd_byte[7];
                        sda_oe <= !rd_byte[7];
                     end
                     else
                        st_ff <= nvs_pkg::ST_DONE;
                  end
                  default: st_ff <= nvs_pkg::ST_IDLE;
               endcase
            end
            else if (scl_fall && st_ff == nvs_pkg::ST_READ && bit_ff != 4'h8)
            begin
               // shift next read bit, open drain
               sda_out <= tx_ff[7];
               sda_oe <= !tx_ff[7];
               tx_ff <= {tx_ff[6:0], 1'b0};
            end
         end
      end
   end

   // =======================================
   // core domain: write request crossing
   logic [2:0] req_sy_ff;
   logic [31:0] cnt_ff;
   logic [7:0] cap_addr_ff, cap_data_ff;
   logic cap_vld_ff;

   // toggle synchroniser, third flop for edge
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         req_sy_ff <= 3'h0;
      else if (ce)
         req_sy_ff <= {req_sy_ff[1:0], req_tgl_ff};
   end

   // power-up recall then nv write timer
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         busy_core_ff <= 1'b1;
         cnt_ff <= 32'(nvs_pkg::PWRUP_CYC);
         cap_vld_ff <= 1'b0;
         cap_addr_ff <= 8'h00;
         cap_data_ff <= 8'h00;
      end
      else if (ce)
      begin
         cap_vld_ff <= 1'b0;
         if (req_sy_ff[2] != req_sy_ff[1])
         begin
            // link data stable while toggle in flight and bus busy
            busy_core_ff <= 1'b1;
            cnt_ff <= 32'(NV_WRITE_CYC);
            cap_addr_ff <= waddr_ff;
            cap_data_ff <= wdata_ff;
         end
         else if (cnt_ff > 32'h1)
            cnt_ff <= cnt_ff - 32'h1;
         else if (busy_core_ff)
         begin
            busy_core_ff <= 1'b0;
            cap_vld_ff <= (cnt_ff == 32'h1) && req_seen_ff;
         end
      end
   end

   // marks that the running timer belongs to a write
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         req_seen_ff <= 1'b0;
      else if (ce)
      begin
         if (req_sy_ff[2] != req_sy_ff[1])
            req_seen_ff <= 1'b1;
         else if (!busy_core_ff)
            req_seen_ff <= 1'b0;
      end
   end

   // =======================================
   // nonvolatile register bank
   genvar gi;
   generate
      for (gi = 0; gi < nvs_pkg::NUM_REGS; gi++)
      begin : g_reg
         always_ff @(posedge clk or negedge nrst)
         begin
            if (!nrst)
               bank_ff[gi] <= nvs_pkg::REG_RST;
            else if (ce && cap_vld_ff && cap_addr_ff == 8'(gi))
               bank_ff[gi] <= cap_data_ff;
         end
      end
   endgenerate

   // settings outputs, straight from flops
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         {reg4_out, reg3_out, reg2_out, reg1_out, reg0_out} <= {5{nvs_pkg::REG_RST}};
         busy_out <= 1'b1;
      end
      else if (ce)
      begin
         {reg4_out, reg3_out, reg2_out, reg1_out, reg0_out}
            <= {bank_ff[4], bank_ff[3], bank_ff[2], bank_ff[1], bank_ff[0]};
         busy_out <= busy_core_ff;
      end
   end
endmodule
`default_nettype wire

// >>> tb/nvs_slave_monitor.sv
// nvs_slave_monitor: port checks for the settings register slave
// assumes: bound to nvs_slave, link pins sampled raw on both clocks
`default_nettype none
module nvs_slave_monitor #(
   parameter int NV_WRITE_CYC = 300
)(
   // clocks and reset
   input wire logic clk,
   input wire logic clk_link,
   input wire logic nrst,
   // serial pins
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic sda_out,
   input wire logic sda_oe,
   // status and settings
   input wire logic busy_out,
   input wire logic [7:0] reg0_out,
   input wire logic [7:0] reg1_out,
   input wire logic [7:0] reg2_out,
   input wire logic [7:0] reg3_out,
   input wire logic [7:0] reg4_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================
   // busy length counter and joined settings
   int bcnt;
   logic [39:0] regs;
   assign regs = {reg4_out, reg3_out, reg2_out, reg1_out, reg0_out};
   always_ff @(posedge clk or negedge nrst)
      if (!nrst)
         bcnt <= 0;
      else
         bcnt <= busy_out ? bcnt + 1 : 0;
   // ==========================================
   // assertions
   oe_after_reset_a: assert property (@(posedge clk) disable iff (!nrst)
      $rose(nrst) |-> !sda_oe) else $error("data line driven after reset");
   busy_quiet_a: assert property (@(posedge clk) disable iff (!nrst)
      busy_out |-> !sda_oe) else $error("data line driven while busy");
   pull_low_a: assert property (@(posedge clk) disable iff (!nrst)
      sda_oe |-> !sda_out) else $error("data line driven high");
   busy_on_stop_a: assert property (@(posedge clk) disable iff (!nrst)
      $rose(busy_out) |-> scl_in && sda_in) else $error("store started off a stop");
   busy_len_a: assert property (@(posedge clk) disable iff (!nrst)
      $fell(busy_out) |-> (bcnt >= NV_WRITE_CYC - 4 && bcnt <= NV_WRITE_CYC + 8)
      || (bcnt >= nvs_pkg::PWRUP_CYC - 4 && bcnt <= nvs_pkg::PWRUP_CYC + 8))
      else $error("busy length wrong");
   store_time_a: assert property (@(posedge clk) disable iff (!nrst)
      regs != $past(regs) |-> !busy_out &&
      ($past(busy_out, 2) || $past(busy_out, 3) || $past(busy_out, 4)))
      else $error("setting changed outside a store");
   oe_scl_low_a: assert property (@(posedge clk_link) disable iff (!nrst)
      $changed(sda_oe) |-> !scl_in) else $error("data changed with clock high");
   oe_hold_a: assert property (@(posedge clk_link) disable iff (!nrst)
      $rose(sda_oe) |-> sda_oe [*8]) else $error("pull dropped too early");
   // main scenario covers
   store_c: cover property (@(posedge clk) $fell(busy_out));
   pull_c: cover property (@(posedge clk_link) $rose(sda_oe));
   update_c: cover property (@(posedge clk) regs != $past(regs));
endmodule
bind nvs_slave nvs_slave_monitor #(.NV_WRITE_CYC(NV_WRITE_CYC)) u_nvs_slave_monitor (
   .clk(clk), .clk_link(clk_link), .nrst(nrst), .scl_in(scl_in), .sda_in(sda_in),
   .sda_out(sda_out), .sda_oe(sda_oe), .busy_out(busy_out), .reg0_out(reg0_out),
   .reg1_out(reg1_out), .reg2_out(reg2_out), .reg3_out(reg3_out), .reg4_out(reg4_out));
`default_nettype wire

// >>> tb/nvs_master.sv
// nvs_master: bit level two-wire bus master facing nvs_slave
// assumes: bench resolves the open-drain wire, pull-up when released
`default_nettype none
module nvs_master (
   // timing reference
   input wire logic clk,
   // wire levels
   input wire logic sda_in,
   output logic scl,
   output logic sda_m
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================
   // idle bus, master owns the clock
   initial
   begin
      scl = 1'h1;
      sda_m = 1'h1;
   end
   // half bit wait on falling clk edges
   task hw(input int n = 48);
      repeat (n) @(negedge clk);
   endtask
   // one clock pulse, data set while low
   task clk_bit;
      hw;
      scl = 1'h1;
      hw;
      scl = 1'h0;
   endtask
   task start;
      sda_m = 1'h1;
      hw;
      scl = 1'h1;
      hw;
      sda_m = 1'h0;
      hw;
      scl = 1'h0;
   endtask
   task stop;
      sda_m = 1'h0;
      hw;
      scl = 1'h1;
      hw;
      sda_m = 1'h1;
      hw;
   endtask
   // send a byte, ack high when pulled low
   task wr(input logic [7:0] b, output logic ack);
      for (int i = 7; i >= 0; i--)
      begin
         sda_m = b[i];
         clk_bit;
      end
      sda_m = 1'h1;
      hw;
      scl = 1'h1;
      hw(24);
      ack = !sda_in;
      hw(24);
      scl = 1'h0;
   endtask
   // read a byte then answer ack or nack
   task rd(output logic [7:0] b, input logic ack_it);
      sda_m = 1'h1;
      for (int i = 7; i >= 0; i--)
      begin
         hw;
         scl = 1'h1;
         hw(24);
         b[i] = sda_in;
         hw(24);
         scl = 1'h0;
      end
      sda_m = !ack_it;
      clk_bit;
      sda_m = 1'h1;
   endtask
endmodule
`default_nettype wire

// >>> tb/tb.sv
// tb: self-checking bench for nvs_slave with a bus master model
// assumes: nvs_pkg and nvs_master compiled first
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, clk_link, nrst, ce, scl, sda_m, sda_in, sda_oe, busy, ack;
   logic [2:0] pins;
   logic [7:0] rdat;
   logic [7:0] regs [5];
   logic [7:0] mem [5];
   int seed, err_count, compares;
   // ==========================================
   // clocks, wired-and data line, design and master
   initial
   begin
      clk = 1'h0;
      forever #2.5 clk = ~clk;
   end
   initial
   begin
      clk_link = 1'h0;
      #7;
      forever #16 clk_link = ~clk_link;
   end
   assign sda_in = sda_m & ~sda_oe;
   nvs_slave #(.NV_WRITE_CYC(300)) u_nvs_slave (.clk(clk), .nrst(nrst), .ce(ce),
      .clk_link(clk_link), .scl_in(scl), .sda_in(sda_in), .sda_out(), .sda_oe(sda_oe),
      .addr_select_pin_high(pins[2]), .addr_select_pin_mid(pins[1]),
      .addr_select_pin_low(pins[0]), .reg0_out(regs[0]), .reg1_out(regs[1]),
      .reg2_out(regs[2]), .reg3_out(regs[3]), .reg4_out(regs[4]), .busy_out(busy));
   nvs_master u_nvs_master (.clk(clk), .sda_in(sda_in), .scl(scl), .sda_m(sda_m));
   // ==========================================
   // expectations and checks
   function automatic logic [7:0] id(logic rw);
      return {nvs_pkg::DEV_CODE, pins, rw};
   endfunction
   function automatic logic [7:0] exp_rd(int p);
      return p <= 4 ? mem[p] : 8'h00;
   endfunction
   task chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp)
      begin
         err_count++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task results;
      if (err_count == 0 && compares > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task wait_idle;
      for (int n = 0; n < 2000 && busy !== 1'h0; n++)
         @(negedge clk);
      repeat (8) @(negedge clk);
      chk({7'h00, busy}, 8'h00);
   endtask
   task chk_regs;
      for (int i = 0; i < 5; i++)
         chk(regs[i], mem[i]);
   endtask
   // start, write id, address byte
   task head(input logic [7:0] a);
      u_nvs_master.start;
      u_nvs_master.wr(id(1'h0), ack);
      chk({7'h00, ack}, 8'h01);
      u_nvs_master.wr(a, ack);
      chk({7'h00, ack}, 8'h01);
   endtask
   // id byte expected to be ignored or refused
   task refused(input logic [7:0] b);
      u_nvs_master.start;
      u_nvs_master.wr(b, ack);
      chk({7'h00, ack}, 8'h00);
      u_nvs_master.stop;
   endtask
   // ==========================================
   // main sequence
   initial
   begin
      seed = 17;
      err_count = 0;
      compares = 0;
      nrst = 1'h0;
      ce = 1'h1;
      pins = 3'($random(seed));
      for (int i = 0; i < 5; i++)
         mem[i] = 8'h00;
      repeat (16) @(posedge clk);
      @(negedge clk) nrst = 1'h1;
      refused(id(1'h0));
      wait_idle;
      chk_regs;
      for (int i = 0; i < 5; i++)
      begin
         @(negedge clk) pins = 3'($random(seed));
         mem[i] = 8'($random(seed));
         head(8'(i));
         u_nvs_master.wr(mem[i], ack);
         chk({7'h00, ack}, 8'h01);
         u_nvs_master.stop;
         chk({7'h00, busy}, 8'h01);
         if (i == 1)
            refused(id(1'h0));
         wait_idle;
         chk_regs;
      end
      // early stop, then stop one bit into the data byte
      for (int k = 0; k < 2; k++)
      begin
         head(8'h02);
         if (k == 1)
            u_nvs_master.clk_bit;
         u_nvs_master.stop;
         repeat (100) @(negedge clk);
         chk({7'h00, busy}, 8'h00);
      end
      chk_regs;
      for (int k = 0; k < 4; k++)
         refused(id(1'h0) ^ (8'h02 << k));
      head(8'h03);
      u_nvs_master.start;
      u_nvs_master.wr(id(1'h1), ack);
      chk({7'h00, ack}, 8'h01);
      for (int j = 0; j < 3; j++)
      begin
         u_nvs_master.rd(rdat, j < 2);
         chk(rdat, exp_rd(3 + j));
      end
      u_nvs_master.stop;
      head(8'h00);
      u_nvs_master.start;
      u_nvs_master.wr(id(1'h1), ack);
      u_nvs_master.rd(rdat, 1'h1);
      chk(rdat, exp_rd(0));
      u_nvs_master.rd(rdat, 1'h0);
      chk(rdat, exp_rd(1));
      u_nvs_master.stop;
      u_nvs_master.start;
      u_nvs_master.wr(id(1'h1), ack);
      chk({7'h00, ack}, 8'h01);
      u_nvs_master.rd(rdat, 1'h0);
      chk(rdat, exp_rd(2));
      u_nvs_master.stop;
      results;
   end
   // watchdog against a hung handshake
   initial
   begin
      #450000;
      err_count++;
      results;
   end
endmodule
`default_nettype wire
